// *** verilog/rbwl_map.svh ***
`ifndef RBWL_MAP_SVH
`define RBWL_MAP_SVH

// Register offsets on the serial register port.
`define RBWL_ADDR_BANK 8'hf0
`define RBWL_ADDR_PRIM 8'hf1
`define RBWL_ADDR_SEC 8'hf2

// Reset values.
`define RBWL_BANK_RST 8'h00
`define RBWL_LOCK_RST 8'h00

// Implemented bits; all other bits are reserved.
`define RBWL_BANK_MASK 8'h01
`define RBWL_LOCK_MASK 8'h3f

// Field positions.
`define RBWL_BANK_BIT 0
`define RBWL_LOCK_CONTROL_WORKING_GROUP 5
`define RBWL_LOCK_SEQUENCE_WORKING_GROUP 4
`define RBWL_LOCK_CFG 3
`define RBWL_LOCK_IEN 2
`define RBWL_LOCK_MON 1
`define RBWL_LOCK_SEQ 0
`define RBWL_GRP_W 6

// Sequence whose exit runs the self-test that clears the locks.
`define RBWL_SHDN_SEQ 2'h2

`endif

// *** verilog/rbwl_pkg.sv ***
package rbwl_pkg;
  // One register byte.
  typedef logic [7:0] rbwl_byte_t;
  // One bit per protected register group.
  typedef logic [5:0] rbwl_grp_t;
  // Sequence number reported by the self-test.
  typedef logic [1:0] rbwl_seq_t;
  // What a host write turned into.
  typedef enum {RBWL_WR_NONE, RBWL_WR_LOCAL, RBWL_WR_PASS, RBWL_WR_DROP} rbwl_wr_kind_t;
endpackage

// *** verilog/rbwl_lock_if.sv ***
interface rbwl_lock_if;
  import rbwl_pkg::*;
  // Host write strobe for this lock register.
  logic wr;
  // Host write data.
  rbwl_byte_t wdata;
  // Clear request from a permitted clearing event.
  logic clr;
  // Current register contents, reserved bits zero.
  rbwl_byte_t q;
  modport ctrl (output wr, output wdata, output clr, input q);
  modport lock (input wr, input wdata, input clr, output q);
endinterface

// *** verilog/rbwl_lock_reg.sv ***
`include "rbwl_map.svh"

// One sticky lock register: bits only rise under host writes.
module rbwl_lock_reg
  import rbwl_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Control side.
  rbwl_lock_if.lock lk
);

  // Stored lock bits.
  rbwl_byte_t lock_reg;
  // Next value of the lock bits.
  rbwl_byte_t lock_next;
  // Bits the current write tries to set.
  rbwl_byte_t set_bits;

  // A written zero never clears a bit; reserved bits are dropped.
  assign set_bits = lk.wr ? (lk.wdata & `RBWL_LOCK_MASK) : `RBWL_LOCK_RST;

  // A set arriving with a clear survives the clear.
  assign lock_next = (lk.clr ? `RBWL_LOCK_RST : lock_reg) | set_bits;

  // Power-on reset leaves every group writable.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lock_reg <= `RBWL_LOCK_RST;
    end else begin
      lock_reg <= lock_next;
    end
  end

  assign lk.q = lock_reg;

endmodule // rbwl_lock_reg

// *** verilog/rbwl_top.sv ***
//Behaviour
//- Bank select bit zero picks bank.
//- Group locked only when both registers set.
//- Both lock registers reset to zero.
//- Host cannot clear a set lock bit.
//- Power cycle or monitor reset clears locks.
//- Shutdown self-test after sequence two clears.
//- Bit five locks control working group.
//- Bit four locks sequence working group.
//- Bit three locks configuration group.
//- Bit two locks interrupt enable group.
//- Bit one locks selected monitor channels.
//- Bit zero locks sequence group.
//- Set lock bits stay read-only until cleared.

`include "rbwl_map.svh"

module rbwl_top
  import rbwl_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Host register port.
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Classification of the addressed register.
  input wire logic [5:0] tgt_group_sel,
  input wire logic [CHANNELS-1:0] tgt_mon_chan,
  input wire logic [CHANNELS-1:0] monitor_lock_select,
  // Clearing events.
  input wire logic monitor_soft_reset,
  input wire logic selftest_done,
  input wire logic [1:0] selftest_exit_seq,
  input wire logic selftest_on_shutdown,
  // Gated write towards the protected registers.
  output logic fwd_wr_en,
  output logic [7:0] fwd_addr,
  output logic [7:0] fwd_wdata,
  output logic fwd_wr_blocked,
  // State for the rest of the device.
  output logic bank_sel,
  output logic [5:0] lock_effective
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // Write aimed at the bank selection register.
  logic hit_bank_wr;
  // Write aimed at the primary lock register.
  logic hit_prim_wr;
  // Write aimed at the secondary lock register.
  logic hit_sec_wr;
  // Write aimed at any register of this block.
  logic hit_local_wr;

  // Each local register answers at one fixed offset.
  assign hit_bank_wr = reg_wr_en && (reg_addr == `RBWL_ADDR_BANK);
  assign hit_prim_wr = reg_wr_en && (reg_addr == `RBWL_ADDR_PRIM);
  assign hit_sec_wr = reg_wr_en && (reg_addr == `RBWL_ADDR_SEC);
  assign hit_local_wr = hit_bank_wr || hit_prim_wr || hit_sec_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Clearing events.

  // Self-test finished on the exit of the shutdown sequence.
  logic selftest_clear;
  // Any event short of reset that wipes the lock bits.
  logic lock_clear;

  // Only counts while the shutdown self-test setting is on.
  assign selftest_clear = selftest_done && selftest_on_shutdown &&
                          (selftest_exit_seq == `RBWL_SHDN_SEQ);

  // The power cycle is the reset inside the lock registers.
  assign lock_clear = monitor_soft_reset || selftest_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Lock registers.

  // Carrier to the primary lock register.
  rbwl_lock_if prim_if ();
  // Carrier to the secondary lock register.
  rbwl_lock_if sec_if ();

  // Both registers see the same clears, so a clear wipes both in the same cycle; writes still reach each one apart.
  assign prim_if.wr = hit_prim_wr;
  assign prim_if.wdata = reg_wdata;
  assign prim_if.clr = lock_clear;
  assign sec_if.wr = hit_sec_wr;
  assign sec_if.wdata = reg_wdata;
  assign sec_if.clr = lock_clear;

  // Primary lock register.
  rbwl_lock_reg u_prim (
    .sys_clk (sys_clk),
    .srst (srst),
    .lk (prim_if.lock)
  );

  // Secondary lock register.
  rbwl_lock_reg u_sec (
    .sys_clk (sys_clk),
    .srst (srst),
    .lk (sec_if.lock)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Effective protection.

  // A group is guarded only when both registers agree.
  rbwl_grp_t lock_both;

  // Reserved bits seven and six never take part in the guard.
  assign lock_both = prim_if.q[`RBWL_GRP_W-1:0] & sec_if.q[`RBWL_GRP_W-1:0];

  // Group guards, one per lock bit.
  logic guard_control_working_group;
  logic guard_sequence_working_group;
  logic guard_cfg;
  logic guard_ien;
  logic guard_mon;
  logic guard_seq;

  // A guard fires when its group is addressed and locked in both registers.
  assign guard_control_working_group = lock_both[`RBWL_LOCK_CONTROL_WORKING_GROUP] && tgt_group_sel[`RBWL_LOCK_CONTROL_WORKING_GROUP];
  assign guard_sequence_working_group = lock_both[`RBWL_LOCK_SEQUENCE_WORKING_GROUP] && tgt_group_sel[`RBWL_LOCK_SEQUENCE_WORKING_GROUP];
  assign guard_cfg = lock_both[`RBWL_LOCK_CFG] && tgt_group_sel[`RBWL_LOCK_CFG];
  assign guard_ien = lock_both[`RBWL_LOCK_IEN] && tgt_group_sel[`RBWL_LOCK_IEN];
  assign guard_seq = lock_both[`RBWL_LOCK_SEQ] && tgt_group_sel[`RBWL_LOCK_SEQ];

  ////////////////////////////////////////////////////////////////////////////
  // Monitor channel selection.

  // Channels whose monitor registers are addressed and selected for locking.
  logic [CHANNELS-1:0] mon_chan_hit;

  // Each channel is locked only if the select register names it.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_mon
      assign mon_chan_hit[ch] = tgt_mon_chan[ch] && monitor_lock_select[ch];
    end
  endgenerate

  // Unselected channels stay writable even with the monitor lock on.
  assign guard_mon = lock_both[`RBWL_LOCK_MON] && tgt_group_sel[`RBWL_LOCK_MON] &&
                     (|mon_chan_hit);

  ////////////////////////////////////////////////////////////////////////////
  // Write classification.

  // Any guard that applies to this write.
  logic write_guarded;
  // Kind of the current host write.
  rbwl_wr_kind_t wr_kind;

  // One guard is enough to discard the write.
  assign write_guarded = guard_control_working_group || guard_sequence_working_group || guard_cfg ||
                         guard_ien || guard_mon || guard_seq;

  // Own registers take priority, then protection decides the rest.
  assign wr_kind = !reg_wr_en ? RBWL_WR_NONE :
                   hit_local_wr ? RBWL_WR_LOCAL :
                   write_guarded ? RBWL_WR_DROP : RBWL_WR_PASS;

  // Forward strobe and drop flag for the next cycle.
  logic fwd_wr_next;
  logic fwd_blk_next;

  // Decode of the write kind; every branch sets both flags.
  always_comb begin
    case (wr_kind)
      RBWL_WR_PASS: begin
        fwd_wr_next = 1'b1;
        fwd_blk_next = 1'b0;
      end
      RBWL_WR_DROP: begin
        fwd_wr_next = 1'b0;
        fwd_blk_next = 1'b1;
      end
      RBWL_WR_LOCAL: begin
        fwd_wr_next = 1'b0;
        fwd_blk_next = 1'b0;
      end
      RBWL_WR_NONE: begin
        fwd_wr_next = 1'b0;
        fwd_blk_next = 1'b0;
      end
      default: begin
        fwd_wr_next = 1'b0;
        fwd_blk_next = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank selection register.

  // Stored bank selection byte.
  rbwl_byte_t bank_reg;
  // Next value of the bank selection byte.
  rbwl_byte_t bank_next;

  // Only bit zero is stored; reserved bits stay zero.
  assign bank_next = hit_bank_wr ? (reg_wdata & `RBWL_BANK_MASK) : bank_reg;

  // Bank selection holds its value between writes.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bank_reg <= `RBWL_BANK_RST;
    end else begin
      bank_reg <= bank_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  // Read data for the addressed register.
  rbwl_byte_t rdata_next;

  // Unmapped addresses read as zero.
  // A read in the cycle of a lock write still shows the old value.
  assign rdata_next = (reg_addr == `RBWL_ADDR_BANK) ? bank_reg :
                      (reg_addr == `RBWL_ADDR_PRIM) ? prim_if.q :
                      (reg_addr == `RBWL_ADDR_SEC) ? sec_if.q : 8'h00;

  // Registered read data.
  rbwl_byte_t rdata_reg;
  // Read answer pulse.
  logic rd_valid_reg;

  // Read data change only when a read is taken.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rdata_reg <= reg_rd_en ? rdata_next : rdata_reg;
      rd_valid_reg <= reg_rd_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forwarded write and state outputs.

  // Registered forward strobe, address and data.
  logic fwd_wr_reg;
  logic fwd_blk_reg;
  rbwl_byte_t fwd_addr_reg;
  rbwl_byte_t fwd_wdata_reg;
  // Registered copies of the state outputs.
  logic bank_out_reg;
  rbwl_grp_t lock_eff_reg;

  // Write strobes are single pulses; address and data hold until next passed write.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fwd_wr_reg <= 1'b0;
      fwd_blk_reg <= 1'b0;
      fwd_addr_reg <= 8'h00;
      fwd_wdata_reg <= 8'h00;
    end else begin
      fwd_wr_reg <= fwd_wr_next;
      fwd_blk_reg <= fwd_blk_next;
      fwd_addr_reg <= fwd_wr_next ? reg_addr : fwd_addr_reg;
      fwd_wdata_reg <= fwd_wr_next ? reg_wdata : fwd_wdata_reg;
    end
  end

  // The one-cycle lag keeps every output a plain flip-flop.
  // State outputs follow the stored registers by one cycle.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bank_out_reg <= 1'b0;
      lock_eff_reg <= 6'h00;
    end else begin
      bank_out_reg <= bank_reg[`RBWL_BANK_BIT];
      lock_eff_reg <= lock_both;
    end
  end

  // Each output is a flip-flop; these lines only rename them.
  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign fwd_wr_en = fwd_wr_reg;
  assign fwd_addr = fwd_addr_reg;
  assign fwd_wdata = fwd_wdata_reg;
  assign fwd_wr_blocked = fwd_blk_reg;
  assign bank_sel = bank_out_reg;
  assign lock_effective = lock_eff_reg;

endmodule // rbwl_top

// *** test/rbwl_top_props.sv ***
//////////////////////////////////////////////////////////////////////
// Checker that watches the ports of the lock block.
module rbwl_top_props #(
  parameter int CHANNELS = 8
) (
  // Clock, reset and host port.
  input wire logic sys_clk, srst, reg_wr_en, reg_rd_en, reg_rd_valid,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  // Classification and clearing events.
  input wire logic [5:0] tgt_group_sel, lock_effective,
  input wire logic [CHANNELS-1:0] tgt_mon_chan, monitor_lock_select,
  input wire logic monitor_soft_reset, selftest_done, selftest_on_shutdown,
  input wire logic [1:0] selftest_exit_seq,
  // Gated write and state outputs.
  input wire logic fwd_wr_en, fwd_wr_blocked, bank_sel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Address falls on one of the three local registers.
  wire own_w = reg_addr[7:2] == 6'h3c && reg_addr[1:0] != 2'h3;
  // Host write that goes towards the protected registers.
  wire ext_wr = reg_wr_en && !own_w;
  // Addressed monitor channel is one that the monitor lock covers.
  wire mon_hit = |(tgt_mon_chan & monitor_lock_select);
  // Shutdown self-test that qualifies as a clearing event.
  wire bist_clr = selftest_done && selftest_on_shutdown && selftest_exit_seq == 2'h2;
  // Any permitted clearing event short of reset.
  wire clr_evt = monitor_soft_reset || bist_clr;
  // Bits that a read of the addressed place may show.
  wire [7:0] rmask = !own_w ? 8'h00 : reg_addr[1:0] == 2'h0 ? 8'h01 : 8'h3f;

  property p_bank; reg_wr_en && reg_addr == 8'hf0 |-> ##2 bank_sel == $past(reg_wdata[0], 2); endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
  property p_rst; $fell(srst) |-> lock_effective == 6'h00 && !bank_sel; endproperty
  a_rst: assert property (p_rst) else $error("state not clear after reset");
  property p_block; ext_wr && !tgt_group_sel[1] |=> fwd_wr_blocked == |($past(tgt_group_sel) & lock_effective);
  endproperty
  a_block: assert property (p_block) else $error("group write gating wrong");
  property p_mon; ext_wr && tgt_group_sel == 6'h02 |=> fwd_wr_blocked == (lock_effective[1] && $past(mon_hit));
  endproperty
  a_mon: assert property (p_mon) else $error("monitor write gating wrong");
  property p_one; ext_wr |=> fwd_wr_en != fwd_wr_blocked; endproperty
  a_one: assert property (p_one) else $error("write neither passed nor dropped");
  property p_stick; |($past(lock_effective) & ~lock_effective) |-> $past(clr_evt, 2); endproperty
  a_stick: assert property (p_stick) else $error("lock bit fell without clear");
  property p_msr; monitor_soft_reset |-> ##2 lock_effective == 6'h00; endproperty
  a_msr: assert property (p_msr) else $error("soft reset left locks");
  property p_bist; bist_clr |-> ##2 lock_effective == 6'h00; endproperty
  a_bist: assert property (p_bist) else $error("self-test left locks");
  property p_rd; reg_rd_en |=> reg_rd_valid && (reg_rdata & ~$past(rmask)) == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read answer wrong");

  // Main scenarios reached.
  c_block: cover property (ext_wr ##1 fwd_wr_blocked);
  c_clr: cover property (clr_evt);
  c_bank: cover property (bank_sel);
endmodule // rbwl_top_props

//////////////////////////////////////////////////////////////////////
bind rbwl_top rbwl_top_props #(.CHANNELS(CHANNELS)) u_props (.sys_clk, .srst, .reg_wr_en, .reg_rd_en,
  .reg_rd_valid, .reg_addr, .reg_wdata, .reg_rdata, .tgt_group_sel, .lock_effective, .tgt_mon_chan,
  .monitor_lock_select, .monitor_soft_reset, .selftest_done, .selftest_on_shutdown, .selftest_exit_seq,
  .fwd_wr_en, .fwd_wr_blocked, .bank_sel);

// *** test/rbwl_host_model.sv ***
//////////////////////////////////////////////////////////////////////
// Host on the register port: one byte per request.
module rbwl_host_model (
  // Clock and answers.
  input wire logic sys_clk,
  input wire logic reg_rd_valid,
  input wire logic [7:0] reg_rdata,
  // Requests.
  output logic reg_wr_en, reg_rd_en,
  output logic [7:0] reg_addr, reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle at time zero.
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Write; released lines show the inverse so stale values never look valid.
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk) #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk) #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Read; the answer stands in the cycle after the taking edge.
  task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge sys_clk) #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    v = reg_rd_valid;
    d = reg_rdata;
  endtask
endmodule // rbwl_host_model

// *** test/rbwl_top_bench.sv ***
//////////////////////////////////////////////////////////////////////
// Self-checking bench for the lock block.
module rbwl_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr_en, reg_rd_en, reg_rd_valid, fwd_wr_en, fwd_wr_blocked, bank_sel, v1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fwd_addr, fwd_wdata, v8;
  logic [5:0] lock_effective;
  logic [5:0] tgt_group_sel = 6'h00;
  logic [7:0] tgt_mon_chan = 8'h00;
  logic [7:0] monitor_lock_select = 8'h00;
  logic monitor_soft_reset = 1'b0;
  logic selftest_done = 1'b0;
  logic selftest_on_shutdown = 1'b0;
  logic [1:0] selftest_exit_seq = 2'h0;
  // Model of both lock registers and the random source.
  logic [7:0] prim = 8'h00;
  logic [7:0] sec = 8'h00;
  logic [7:0] lf = 8'h30;
  int num_errors = 0;
  int tests_run = 0;

  rbwl_top dut (.sys_clk, .srst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
    .tgt_group_sel, .tgt_mon_chan, .monitor_lock_select, .monitor_soft_reset, .selftest_done,
    .selftest_exit_seq, .selftest_on_shutdown, .fwd_wr_en, .fwd_addr, .fwd_wdata, .fwd_wr_blocked,
    .bank_sel, .lock_effective);
  rbwl_host_model u_host (.sys_clk, .reg_rd_valid, .reg_rdata, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata);

  initial forever #10 sys_clk = ~sys_clk;

  // Next random byte.
  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // Expected drop of a write to group g under the modelled locks.
  function automatic logic blk(input logic [5:0] g);
    logic [5:0] l;
    l = prim[5:0] & sec[5:0];
    return |(g & l & 6'h3d) || (g[1] && l[1] && |(tgt_mon_chan & monitor_lock_select));
  endfunction
  // Compare and count.
  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Register write that also updates the model; set bits never fall.
  task automatic wreg(input logic [7:0] a, d);
    u_host.wr(a, d);
    if (a == 8'hf1) prim = prim | (d & 8'h3f);
    if (a == 8'hf2) sec = sec | (d & 8'h3f);
  endtask
  // Read with a check of the answer strobe and data.
  task automatic rdchk(input logic [7:0] a, e);
    u_host.rd(a, v1, v8);
    chk({7'h00, v1}, 8'h01);
    chk(v8, e);
  endtask
  // Write to a protected place of group g and check its fate.
  task automatic fw(input logic [5:0] g);
    logic b;
    tgt_group_sel = g;
    b = blk(g);
    lf = nxt(lf);
    u_host.wr({1'b0, lf[6:0]}, lf);
    chk({6'h00, fwd_wr_blocked, fwd_wr_en}, {6'h00, b, !b});
    if (!b) chk(fwd_wdata, lf);
    if (!b) chk(fwd_addr, {1'b0, lf[6:0]});
  endtask
  // Clearing-event pulse; clr says whether the locks must drop.
  task automatic ev(input logic m, d, s, input logic [1:0] q, input logic clr);
    monitor_soft_reset = m;
    selftest_done = d;
    selftest_on_shutdown = s;
    selftest_exit_seq = q;
    @(posedge sys_clk) #1;
    monitor_soft_reset = 1'b0;
    selftest_done = 1'b0;
    if (clr) {prim, sec} = 16'h0000;
    @(posedge sys_clk) #1;
  endtask
  // Verdict.
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 srst = 1'b0;
    rdchk(8'hf1, 8'h00);
    rdchk(8'hf2, 8'h00);
    rdchk(8'h10, 8'h00);
    $display("test reset done");
    wreg(8'hf0, 8'hff);
    rdchk(8'hf0, 8'h01);
    chk({7'h00, bank_sel}, 8'h01);
    wreg(8'hf0, 8'hfe);
    rdchk(8'hf0, 8'h00);
    $display("test bank done");
    for (int i = 0; i < 12; i++) begin
      lf = nxt(lf);
      tgt_mon_chan = 8'h01 << lf[2:0];
      monitor_lock_select = nxt(lf);
      wreg(i[0] ? 8'hf2 : 8'hf1, i % 3 == 2 ? 8'h00 : lf);
      rdchk(8'hf1, prim);
      rdchk(8'hf2, sec);
      chk({2'h0, lock_effective}, prim & sec);
      for (int g = 0; g < 6; g++) fw(6'h01 << g);
    end
    $display("test locks done");
    ev(1'b0, 1'b1, 1'b1, 2'h1, 1'b0);
    ev(1'b0, 1'b1, 1'b0, 2'h2, 1'b0);
    rdchk(8'hf1, prim);
    ev(1'b0, 1'b1, 1'b1, 2'h2, 1'b1);
    rdchk(8'hf2, 8'h00);
    wreg(8'hf1, 8'hff);
    wreg(8'hf2, 8'h3f);
    fw(6'h08);
    ev(1'b1, 1'b0, 1'b0, 2'h0, 1'b1);
    rdchk(8'hf1, 8'h00);
    fw(6'h08);
    monitor_soft_reset = 1'b1;
    wreg(8'hf1, 8'h04);
    monitor_soft_reset = 1'b0;
    rdchk(8'hf1, 8'h04);
    wreg(8'hf1, 8'h3f);
    srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 srst = 1'b0;
    {prim, sec} = 16'h0000;
    rdchk(8'hf1, 8'h00);
    $display("test clears done");
    close_out();
  end

  // Hang guard.
  initial begin
    #1000000;
    num_errors++;
    close_out();
  end
endmodule // rbwl_top_bench
